// file: design/pressure_cmd_pkg.sv
// shared constants, carriers and helpers for the pressure sensor command block
package pressure_cmd_pkg;

   localparam int CLK_MHZ = 10;

   localparam logic [6:0] SLAVE_ADDR = 7'h76;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;

   localparam logic [7:0] CMD_RESET = 8'h1E;
   localparam logic [7:0] CMD_RESULT_READ = 8'h00;
   localparam logic [2:0] CMD_CONVERSION_SELECT_BIT_PREFIX = 3'h2;
   localparam logic [2:0] CMD_CAL_PREFIX = 3'h5;
   localparam logic [2:0] OSR_CODE_MAX = 3'h5;

   localparam int CAL_WORDS = 7;
   localparam int CAL_WORD_W = 16;
   localparam int RESULT_W = 24;
   localparam int BYTE_W = 8;
   localparam logic [23:0] RESULT_ZERO = 24'h000000;
   localparam logic [23:0] RESULT_CORRUPT_MASK = 24'hFFFFFF;

   // longest conversion time per oversampling ratio, in microseconds
   localparam int CONVERSION_SELECT_BIT_MAX_US_OSR256 = 560;
   localparam int CONVERSION_SELECT_BIT_MAX_US_OSR512 = 1100;
   localparam int CONVERSION_SELECT_BIT_MAX_US_OSR1024 = 2170;
   localparam int CONVERSION_SELECT_BIT_MAX_US_OSR2048 = 4320;
   localparam int CONVERSION_SELECT_BIT_MAX_US_OSR4096 = 8610;
   localparam int CONVERSION_SELECT_BIT_MAX_US_OSR8192 = 17200;
   localparam int CONVERSION_SELECT_BIT_CYC_OSR256 = CONVERSION_SELECT_BIT_MAX_US_OSR256 * CLK_MHZ;
   localparam int CONVERSION_SELECT_BIT_CYC_OSR512 = CONVERSION_SELECT_BIT_MAX_US_OSR512 * CLK_MHZ;
   localparam int CONVERSION_SELECT_BIT_CYC_OSR1024 = CONVERSION_SELECT_BIT_MAX_US_OSR1024 * CLK_MHZ;
   localparam int CONVERSION_SELECT_BIT_CYC_OSR2048 = CONVERSION_SELECT_BIT_MAX_US_OSR2048 * CLK_MHZ;
   localparam int CONVERSION_SELECT_BIT_CYC_OSR4096 = CONVERSION_SELECT_BIT_MAX_US_OSR4096 * CLK_MHZ;
   localparam int CONVERSION_SELECT_BIT_CYC_OSR8192 = CONVERSION_SELECT_BIT_MAX_US_OSR8192 * CLK_MHZ;
   localparam int CONVERSION_SELECT_BIT_CNT_W = 18;

   typedef struct packed {
      logic cal_access_bit;
      logic conversion_select_bit;
      logic reserved_bit;
      logic sample_type_bit;
      logic select_code_bit2;
      logic select_code_bit1;
      logic select_code_bit0;
      logic stop_bit;
   } cmd_fields_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic sda;
   } line_evt_t;

   typedef enum {READ_NONE, READ_RESULT, READ_CAL} read_mode_t;

   function automatic logic [2:0] select_code(input cmd_fields_t c);
      return {c.select_code_bit2, c.select_code_bit1, c.select_code_bit0};
   endfunction

endpackage

// file: design/i2c_line_monitor.sv
// pin synchronisers plus start, stop and clock edge detection
`timescale 1ns/100ps
module i2c_line_monitor
   import pressure_cmd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output line_evt_t evt_o
);

   logic scl_meta_r;
   logic scl_sync_r;
   logic scl_prev_r;
   logic sda_meta_r;
   logic sda_sync_r;
   logic sda_prev_r;

   // bus idles high, so reset to the released level
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_meta_r <= 1'b1;
         scl_sync_r <= 1'b1;
         scl_prev_r <= 1'b1;
         sda_meta_r <= 1'b1;
         sda_sync_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else begin
         scl_meta_r <= scl_i;
         scl_sync_r <= scl_meta_r;
         scl_prev_r <= scl_sync_r;
         sda_meta_r <= sda_i;
         sda_sync_r <= sda_meta_r;
         sda_prev_r <= sda_sync_r;
      end
   end

   // start and stop only count while the clock stays high
   always_comb begin
      evt_o.start = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
      evt_o.stop = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;
      evt_o.scl_rise = scl_sync_r & ~scl_prev_r;
      evt_o.scl_fall = ~scl_sync_r & scl_prev_r;
      evt_o.sda = sda_sync_r;
   end

endmodule

// file: design/conversion_select_bit_timer.sv
// conversion duration timer, one length per oversampling ratio
`timescale 1ns/100ps
module conversion_select_bit_timer
   import pressure_cmd_pkg::*;
#(
   parameter int unsigned CYC_OSR256 = CONVERSION_SELECT_BIT_CYC_OSR256,
   parameter int unsigned CYC_OSR512 = CONVERSION_SELECT_BIT_CYC_OSR512,
   parameter int unsigned CYC_OSR1024 = CONVERSION_SELECT_BIT_CYC_OSR1024,
   parameter int unsigned CYC_OSR2048 = CONVERSION_SELECT_BIT_CYC_OSR2048,
   parameter int unsigned CYC_OSR4096 = CONVERSION_SELECT_BIT_CYC_OSR4096,
   parameter int unsigned CYC_OSR8192 = CONVERSION_SELECT_BIT_CYC_OSR8192
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic [2:0] osr_code_i,
   output logic busy_o,
   output logic done_o
);

   logic [CONVERSION_SELECT_BIT_CNT_W-1:0] remain_r;

   function automatic logic [CONVERSION_SELECT_BIT_CNT_W-1:0] conversion_select_bit_len(input logic [2:0] code);
      case (code)
         3'h0: conversion_select_bit_len = CONVERSION_SELECT_BIT_CNT_W'(CYC_OSR256);
         3'h1: conversion_select_bit_len = CONVERSION_SELECT_BIT_CNT_W'(CYC_OSR512);
         3'h2: conversion_select_bit_len = CONVERSION_SELECT_BIT_CNT_W'(CYC_OSR1024);
         3'h3: conversion_select_bit_len = CONVERSION_SELECT_BIT_CNT_W'(CYC_OSR2048);
         3'h4: conversion_select_bit_len = CONVERSION_SELECT_BIT_CNT_W'(CYC_OSR4096);
         default: conversion_select_bit_len = CONVERSION_SELECT_BIT_CNT_W'(CYC_OSR8192);
      endcase
   endfunction

   // a new start reloads the count: the running conversion is simply replaced
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         remain_r <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (abort_i) begin
            remain_r <= '0;
            busy_o <= 1'b0;
         end else if (start_i) begin
            remain_r <= conversion_select_bit_len(osr_code_i);
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (remain_r == CONVERSION_SELECT_BIT_CNT_W'(1)) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            remain_r <= remain_r - CONVERSION_SELECT_BIT_CNT_W'(1);
         end
      end
   end

endmodule

// file: design/pressure_sensor_i2c_cmd.sv
// i2c command slave of a pressure and temperature sensor
//
// Contract
// - every command is one byte after write address
// - answer only to seven-bit address 1110110
// - reset command 0x1E accepted at any time
// - reset reloads calibration memory into register
// - after 0x00, next read returns 24-bit result
// - calibration read codes 0xA0 to 0xAE
// - calibration word is 16 bits, msb first
// - seven 16-bit calibration words, 112 bits
// - calibration read is write then read
// - result read returns zero without new conversion
// - read during conversion gives zero, corrupts result
// - conversion command during conversion corrupts outcome
// - 0x40-0x4A pressure, 0x50-0x5A temperature, six ratios
// - busy until conversion completes, then result
// - 24 clocks shift result out msb first
// - wait for host acknowledge after each byte
// - raw samples are unsigned 24-bit values
// - word zero carries a 4-bit checksum on top
`timescale 1ns/100ps
module pressure_sensor_i2c_cmd
   import pressure_cmd_pkg::*;
#(
   parameter int unsigned CYC_OSR256 = CONVERSION_SELECT_BIT_CYC_OSR256,
   parameter int unsigned CYC_OSR512 = CONVERSION_SELECT_BIT_CYC_OSR512,
   parameter int unsigned CYC_OSR1024 = CONVERSION_SELECT_BIT_CYC_OSR1024,
   parameter int unsigned CYC_OSR2048 = CONVERSION_SELECT_BIT_CYC_OSR2048,
   parameter int unsigned CYC_OSR4096 = CONVERSION_SELECT_BIT_CYC_OSR4096,
   parameter int unsigned CYC_OSR8192 = CONVERSION_SELECT_BIT_CYC_OSR8192
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_b_o,
   input wire logic [CAL_WORDS*CAL_WORD_W-1:0] cal_rom_i,
   input wire logic [RESULT_W-1:0] raw_pressure_sample_i,
   input wire logic [RESULT_W-1:0] raw_temperature_sample_i,
   output logic busy_o,
   output logic result_ready_o,
   output logic cal_loaded_o
);

   typedef enum {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK
   } bus_state_t;

   line_evt_t evt;
   bus_state_t state_r;
   logic [2:0] bit_cnt_r;
   logic [BYTE_W-1:0] rx_sr_r;
   logic [RESULT_W-1:0] tx_sr_r;
   logic cmd_taken_r;
   logic rw_r;
   logic bit_seen_r;

   logic [CAL_WORD_W-1:0] cal_mem_r [CAL_WORDS];
   read_mode_t read_mode_r;
   logic [2:0] cal_addr_r;

   logic [RESULT_W-1:0] result_r;
   logic conversion_select_bit_type_r;
   logic conversion_select_bit_corrupt_r;
   logic [2:0] conversion_select_bit_osr_r;
   logic conversion_select_bit_start;
   logic conversion_select_bit_done;
   logic conversion_select_bit_busy;

   logic [BYTE_W-1:0] cmd_byte;
   cmd_fields_t cmd;
   logic cmd_strobe;
   logic is_reset_cmd;
   logic is_read_cmd;
   logic is_conversion_select_bit_cmd;
   logic is_cal_cmd;
   logic rd_addr_take;
   logic [RESULT_W-1:0] tx_load;

   i2c_line_monitor u_line (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .evt_o(evt)
   );

   conversion_select_bit_timer #(
      .CYC_OSR256(CYC_OSR256),
      .CYC_OSR512(CYC_OSR512),
      .CYC_OSR1024(CYC_OSR1024),
      .CYC_OSR2048(CYC_OSR2048),
      .CYC_OSR4096(CYC_OSR4096),
      .CYC_OSR8192(CYC_OSR8192)
   ) u_timer (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .start_i(conversion_select_bit_start),
      .abort_i(cmd_strobe && is_reset_cmd),
      .osr_code_i(select_code(cmd)),
      .busy_o(conversion_select_bit_busy),
      .done_o(conversion_select_bit_done)
   );

   // command byte completes on the eighth falling clock of the data byte
   assign cmd_byte = rx_sr_r;
   assign cmd = cmd_fields_t'(cmd_byte);
   assign cmd_strobe = evt.scl_fall && state_r == ST_WR_BYTE &&
                       bit_cnt_r == 3'h7 && !cmd_taken_r;
   assign is_reset_cmd = cmd_byte == CMD_RESET;
   assign is_read_cmd = cmd_byte == CMD_RESULT_READ;
   assign is_conversion_select_bit_cmd = {cmd.cal_access_bit, cmd.conversion_select_bit, cmd.reserved_bit}
                        == CMD_CONVERSION_SELECT_BIT_PREFIX && !cmd.stop_bit &&
                        select_code(cmd) <= OSR_CODE_MAX;
   assign is_cal_cmd = {cmd.cal_access_bit, cmd.conversion_select_bit, cmd.reserved_bit}
                       == CMD_CAL_PREFIX && !cmd.sample_type_bit && !cmd.stop_bit;
   assign conversion_select_bit_start = cmd_strobe && is_conversion_select_bit_cmd;

   // read address acknowledged: the answer word is latched for shifting
   assign rd_addr_take = evt.scl_fall && state_r == ST_ADDR_ACK && rw_r == RW_READ;

   always_comb begin
      tx_load = RESULT_ZERO;
      case (read_mode_r)
         READ_RESULT: begin
            if (result_ready_o && !conversion_select_bit_busy) begin
               tx_load = result_r;
            end
         end
         READ_CAL: begin
            if (cal_addr_r < 3'(CAL_WORDS)) begin
               tx_load = {cal_mem_r[cal_addr_r], RESULT_ZERO[BYTE_W-1:0]};
            end
         end
         default: tx_load = RESULT_ZERO;
      endcase
   end

   // bus protocol engine; sda changes after a falling clock, and is released on start and stop
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         rx_sr_r <= '0;
         tx_sr_r <= '0;
         rw_r <= RW_WRITE;
         cmd_taken_r <= 1'b0;
         bit_seen_r <= 1'b0;
         sda_oe_b_o <= 1'b1;
      end else if (evt.stop) begin
         state_r <= ST_IDLE;
         sda_oe_b_o <= 1'b1;
      end else if (evt.start) begin
         state_r <= ST_ADDR;
         bit_cnt_r <= 3'h0;
         bit_seen_r <= 1'b0;
         cmd_taken_r <= 1'b0;
         sda_oe_b_o <= 1'b1;
      end else if (evt.scl_rise) begin
         bit_seen_r <= 1'b1;
         if (state_r == ST_ADDR || state_r == ST_WR_BYTE) begin
            rx_sr_r <= {rx_sr_r[BYTE_W-2:0], evt.sda};
         end else if (state_r == ST_RD_ACK) begin
            rx_sr_r <= {rx_sr_r[BYTE_W-2:0], evt.sda};
         end
      end else if (evt.scl_fall) begin
         case (state_r)
            ST_ADDR: begin
               // the falling clock that ends a start carries no bit
               if (!bit_seen_r) begin
                  bit_cnt_r <= 3'h0;
               end else if (bit_cnt_r == 3'h7) begin
                  bit_cnt_r <= 3'h0;
                  if (rx_sr_r[BYTE_W-1:1] == SLAVE_ADDR) begin
                     state_r <= ST_ADDR_ACK;
                     rw_r <= rx_sr_r[0];
                     sda_oe_b_o <= 1'b0;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end else begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
               end
            end
            ST_ADDR_ACK: begin
               bit_cnt_r <= 3'h0;
               if (rw_r == RW_READ) begin
                  state_r <= ST_RD_BYTE;
                  tx_sr_r <= tx_load;
                  sda_oe_b_o <= tx_load[RESULT_W-1];
               end else begin
                  state_r <= ST_WR_BYTE;
                  sda_oe_b_o <= 1'b1;
               end
            end
            ST_WR_BYTE: begin
               if (bit_cnt_r == 3'h7) begin
                  bit_cnt_r <= 3'h0;
                  // a second byte in one message is not acknowledged
                  if (!cmd_taken_r) begin
                     state_r <= ST_WR_ACK;
                     cmd_taken_r <= 1'b1;
                     sda_oe_b_o <= 1'b0;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end else begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
               end
            end
            ST_WR_ACK: begin
               state_r <= ST_WR_BYTE;
               sda_oe_b_o <= 1'b1;
            end
            ST_RD_BYTE: begin
               tx_sr_r <= {tx_sr_r[RESULT_W-2:0], 1'b0};
               if (bit_cnt_r == 3'h7) begin
                  state_r <= ST_RD_ACK;
                  sda_oe_b_o <= 1'b1;
               end else begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  sda_oe_b_o <= tx_sr_r[RESULT_W-2];
               end
            end
            ST_RD_ACK: begin
               bit_cnt_r <= 3'h0;
               // host ack drives sda low; a nack ends our part of the read
               if (!rx_sr_r[0]) begin
                  state_r <= ST_RD_BYTE;
                  sda_oe_b_o <= tx_sr_r[RESULT_W-1];
               end else begin
                  state_r <= ST_IDLE;
                  sda_oe_b_o <= 1'b1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               sda_oe_b_o <= 1'b1;
            end
         endcase
      end
   end

   // open-drain: only ever pulls low, the enable decides
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // what a following read transaction returns
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         read_mode_r <= READ_NONE;
         cal_addr_r <= 3'h0;
      end else if (cmd_strobe) begin
         if (is_cal_cmd) begin
            read_mode_r <= READ_CAL;
            cal_addr_r <= select_code(cmd);
         end else if (is_read_cmd) begin
            read_mode_r <= READ_RESULT;
         end else begin
            read_mode_r <= READ_NONE;
         end
      end
   end

   // calibration memory: loaded after power-on release and on reset command
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cal_loaded_o <= 1'b0;
         for (int i = 0; i < CAL_WORDS; i++) begin
            cal_mem_r[i] <= '0;
         end
      end else if (cmd_strobe && is_reset_cmd) begin
         cal_loaded_o <= 1'b0;
      end else if (!cal_loaded_o) begin
         cal_loaded_o <= 1'b1;
         // word zero keeps its checksum nibble on top, untouched
         for (int i = 0; i < CAL_WORDS; i++) begin
            cal_mem_r[i] <= cal_rom_i[i*CAL_WORD_W +: CAL_WORD_W];
         end
      end
   end

   // conversion bookkeeping and the stored result
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         conversion_select_bit_type_r <= 1'b0;
         conversion_select_bit_osr_r <= 3'h0;
         conversion_select_bit_corrupt_r <= 1'b0;
         result_r <= RESULT_ZERO;
         result_ready_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         busy_o <= conversion_select_bit_busy || conversion_select_bit_start;
         if (cmd_strobe && is_reset_cmd) begin
            conversion_select_bit_corrupt_r <= 1'b0;
            result_ready_o <= 1'b0;
            result_r <= RESULT_ZERO;
         end else if (conversion_select_bit_start) begin
            conversion_select_bit_type_r <= cmd.sample_type_bit;
            conversion_select_bit_osr_r <= select_code(cmd);
            conversion_select_bit_corrupt_r <= conversion_select_bit_busy;
            result_ready_o <= 1'b0;
         end else if (conversion_select_bit_done) begin
            // raw samples kept as unsigned 24-bit words
            result_r <= (conversion_select_bit_type_r ? raw_temperature_sample_i : raw_pressure_sample_i) ^
                        (conversion_select_bit_corrupt_r ? RESULT_CORRUPT_MASK : RESULT_ZERO);
            result_ready_o <= 1'b1;
            conversion_select_bit_corrupt_r <= 1'b0;
         end else if (rd_addr_take && read_mode_r == READ_RESULT) begin
            // a read mid-conversion answers zero and spoils the running one
            if (conversion_select_bit_busy) begin
               conversion_select_bit_corrupt_r <= 1'b1;
            end
            result_ready_o <= 1'b0;
            result_r <= RESULT_ZERO;
         end
      end
   end

endmodule

// file: tb/pressure_cmd_monitor.sv
// assertion checker for the pressure sensor command block
`timescale 1ns/100ps
module pressure_cmd_monitor
   import pressure_cmd_pkg::*;
#(
   parameter int unsigned CYC_OSR256 = CONVERSION_SELECT_BIT_CYC_OSR256
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_b_o,
   input wire logic busy_o,
   input wire logic result_ready_o,
   input wire logic cal_loaded_o
);
   int unsigned busy_len;
   int unsigned low_len;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // run lengths kept in counters, far too long for repetition operators
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_len <= 0;
      end else begin
         busy_len <= busy_o ? busy_len + 1 : 0;
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         low_len <= 0;
      end else begin
         low_len <= !sda_oe_b_o ? low_len + 1 : 0;
      end
   end
   sequence conversion_select_bit_start;
      $rose(busy_o);
   endsequence
   sequence conversion_select_bit_hold;
      busy_o [*8];
   endsequence
   busy_holds_a: assert property (conversion_select_bit_start |-> conversion_select_bit_hold)
      else $error("busy dropped too soon");
   ready_cause_a: assert property (
      $rose(result_ready_o) |-> $fell(busy_o) && busy_len >= CYC_OSR256 - 2)
      else $error("result ready without a full conversion");
   busy_ready_a: assert property (!(busy_o && result_ready_o))
      else $error("result offered while busy");
   cal_load_a: assert property ($rose(rst_b_i) |=> cal_loaded_o)
      else $error("calibration not loaded after reset");
   cal_reload_a: assert property ($fell(cal_loaded_o) |=> cal_loaded_o)
      else $error("calibration reload too slow");
   reset_abort_a: assert property (
      $fell(cal_loaded_o) |-> ##[0:1] (!busy_o && !result_ready_o))
      else $error("reset command left a conversion");
   no_glitch_a: assert property ($changed(sda_oe_b_o) |-> !scl_i)
      else $error("data line moved while clock high");
   open_drain_a: assert property (sda_oe_b_o || sda_o == 1'b0)
      else $error("data line driven high");
   low_len_a: assert property (low_len < 90)
      else $error("data line held past one byte");
endmodule

bind pressure_sensor_i2c_cmd pressure_cmd_monitor #(.CYC_OSR256(CYC_OSR256)) mon_inst (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_b_o(sda_oe_b_o), .busy_o(busy_o), .result_ready_o(result_ready_o),
   .cal_loaded_o(cal_loaded_o));

// file: tb/host_i2c_model.sv
// i2c host master model, clock 5 cycles low and 3 high
`timescale 1ns/100ps
module host_i2c_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // clock stands high between frames
   task automatic start_c();
      tick(1);
      sda_o <= 1'b1;
      tick(1);
      scl_o <= 1'b1;
      tick(3);
      sda_o <= 1'b0;
      tick(3);
      scl_o <= 1'b0;
   endtask
   task automatic stop_c();
      tick(2);
      sda_o <= 1'b0;
      tick(3);
      scl_o <= 1'b1;
      tick(3);
      sda_o <= 1'b1;
      tick(4);
   endtask
   // data set mid low phase, well clear of the device's late changes
   task automatic bit_out(input logic b);
      tick(2);
      sda_o <= b;
      tick(3);
      scl_o <= 1'b1;
      tick(3);
      scl_o <= 1'b0;
   endtask
   // clocks with data released free a device stuck in an ack
   task automatic clear_bus();
      repeat (9) bit_out(1'b1);
   endtask
   task automatic bit_in(output logic b);
      tick(2);
      sda_o <= 1'b1;
      tick(3);
      scl_o <= 1'b1;
      tick(2);
      b = sda_i;
      tick(1);
      scl_o <= 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(b);
      ack = !b;
   endtask
   task automatic get_byte(input logic ack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bit_in(d[i]);
      end
      bit_out(!ack);
   endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the pressure sensor command block
`timescale 1ns/100ps
module tb_top;
   import pressure_cmd_pkg::*;
   localparam int C0 = 400;
   logic clk_i;
   logic rst_b_i;
   logic scl, host_sda, sda_out, sda_oe_b, busy, ready, loaded;
   logic [111:0] cal_rom;
   logic [23:0] p_smp, t_smp;
   int error_cnt = 0;
   int n_tests = 0;
   // pull-up: line is high unless someone pulls it low
   wire sda_bus = host_sda & (sda_oe_b | sda_out);
   pressure_sensor_i2c_cmd #(.CYC_OSR256(C0), .CYC_OSR512(C0 + 100),
      .CYC_OSR1024(C0 + 200), .CYC_OSR2048(C0 + 300), .CYC_OSR4096(C0 + 400),
      .CYC_OSR8192(C0 + 500)) pressure_sensor_i2c_cmd_inst (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_bus),
      .sda_o(sda_out), .sda_oe_b_o(sda_oe_b), .cal_rom_i(cal_rom),
      .raw_pressure_sample_i(p_smp), .raw_temperature_sample_i(t_smp),
      .busy_o(busy), .result_ready_o(ready), .cal_loaded_o(loaded));
   host_i2c_model host_i2c_model_inst (
      .clk_i(clk_i), .sda_i(sda_bus), .scl_o(scl), .sda_o(host_sda));
   task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic send_cmd(input logic [7:0] c);
      logic a0, a1;
      host_i2c_model_inst.start_c();
      host_i2c_model_inst.put_byte({SLAVE_ADDR, RW_WRITE}, a0);
      host_i2c_model_inst.put_byte(c, a1);
      host_i2c_model_inst.stop_c();
      check("cmd ack", {22'h0, a0, a1}, 24'h000003);
   endtask
   task automatic read_bytes(output logic [23:0] v);
      logic a;
      logic [7:0] d;
      v = 24'h0;
      host_i2c_model_inst.start_c();
      host_i2c_model_inst.put_byte({SLAVE_ADDR, RW_READ}, a);
      check("read ack", {23'h0, a}, 24'h000001);
      for (int i = 0; i < 3; i++) begin
         host_i2c_model_inst.get_byte(i < 2, d);
         v = {v[15:0], d};
      end
      host_i2c_model_inst.stop_c();
   endtask
   task automatic read_result(input string nm, input logic [23:0] exp);
      logic [23:0] v;
      send_cmd(CMD_RESULT_READ);
      read_bytes(v);
      check(nm, v, exp);
   endtask
   // the host waits out the conversion before asking for the result
   task automatic wait_ready();
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 2000) begin
         @(posedge clk_i);
         k++;
      end
      if (k == 2000) begin
         check("ready timeout", 24'h1, 24'h0);
         print_verdict();
      end
   endtask
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      logic [23:0] v;
      logic a;
      rst_b_i = 1'b0;
      cal_rom = 112'h6E5D_4C3B_2A19_0817_F6E5_D4C3_B2A1;
      p_smp = 24'h8A1234;
      t_smp = 24'hF39876;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("cal loaded", {23'h0, loaded}, 24'h1);
      host_i2c_model_inst.clear_bus();
      send_cmd(CMD_RESET);
      // address 7 holds no word; second pass repeats the selected word
      for (int i = 0; i < 8; i++) begin
         send_cmd({CMD_CAL_PREFIX, 1'b0, 3'(i), 1'b0});
         for (int r = 0; r < 2; r++) begin
            read_bytes(v);
            check("cal word", v, (i < 7) ? {cal_rom[16*i +: 16], 8'h00} : 24'h0);
         end
      end
      host_i2c_model_inst.start_c();
      host_i2c_model_inst.put_byte({7'h77, RW_WRITE}, a);
      host_i2c_model_inst.stop_c();
      check("foreign addr ack", {23'h0, a}, 24'h0);
      read_result("idle result", RESULT_ZERO);
      for (int k = 0; k < 12; k++) begin
         @(posedge clk_i);
         p_smp <= 24'h8A1234 + 24'(k);
         t_smp <= 24'hF39876 - 24'(k);
         send_cmd({CMD_CONVERSION_SELECT_BIT_PREFIX, k >= 6, 3'(k % 6), 1'b0});
         check("busy ready", {22'h0, busy, ready}, 24'h000002);
         wait_ready();
         read_result("result", k >= 6 ? t_smp : p_smp);
         read_result("repeat read", RESULT_ZERO);
      end
      send_cmd(8'h48);
      read_result("read while busy", RESULT_ZERO);
      wait_ready();
      read_result("spoiled by read", p_smp ^ RESULT_CORRUPT_MASK);
      send_cmd(8'h40);
      send_cmd(8'h42);
      wait_ready();
      read_result("spoiled by restart", p_smp ^ RESULT_CORRUPT_MASK);
      send_cmd(8'h5A);
      send_cmd(CMD_RESET);
      repeat (3) @(posedge clk_i);
      check("reset abort", {21'h0, busy, ready, loaded}, 24'h000001);
      read_result("after reset", RESULT_ZERO);
      print_verdict();
   end
endmodule
